// file: design/dtw_top.sv
`timescale 1ns/1ps
`include "dtw_cfg.svh"
module dtw_top
  import dtw_pkg::*;
#(
  parameter int DEAD_W = 16
) (
  // clock, reset, enable
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // sources from compare unit and pulse generator
  input wire logic compare_sig_zero,
  input wire logic compare_sig_one,
  input wire logic pulse_gen_input,
  // waveform outputs
  output logic wave_out_zero,
  output logic wave_out_one,
  output logic pulse_gen_gate_out
);

  // polarity applied to a normal-polarity pair
  function automatic dtw_pair_t apply_pol(input logic [1:0] pol, input logic n0, input logic n1);
    dtw_pair_t p;
    p.wave_out_zero = n0 ^ pol[0];
    p.wave_out_one = n1 ^ (pol[0] ^ pol[1]);
    return p;
  endfunction : apply_pol

  // true on cycles where the prescaler lets the timer step
  function automatic logic div_tick(input logic [2:0] dv, input logic [6:0] pre);
    logic [6:0] mask;
    mask = 7'((8'h01 << dv) - 8'h01);
    return (pre & mask) == 7'h00;
  endfunction : div_tick

  dtw_ctrl_t ctrl_q;
  logic [DEAD_W-1:0] dead_q;
  logic [DEAD_W-1:0] cnt_q;
  dtw_phase_t phase_q;
  logic [6:0] pre_q;
  logic src_q;
  logic n0_q;
  logic n1_q;
  logic n0_d;
  logic n1_d;
  logic wr_pend_q;
  logic [11:0] wr_addr_q;
  logic [31:0] rdata_d;
  logic wr_ctrl;
  logic wr_dead;
  logic addr_ok;
  logic cmp_mode;
  logic pg_mode;
  logic dead_mode;
  logic src;
  logic edge_det;
  logic tick;
  logic expire;
  logic preset;
  logic [2:0] new_mode;
  logic new_dead_mode;
  logic new_src;
  dtw_pair_t pair_d;

  // bus decode
  assign addr_ok = hsel & hready & htrans[1];
  assign wr_ctrl = wr_pend_q & (wr_addr_q == `DTW_CTRL_OFS);
  assign wr_dead = wr_pend_q & (wr_addr_q == `DTW_DEAD_OFS);

  assign cmp_mode = ctrl_q.operating_mode_sel == `DTW_MODE_CMP_DEAD;
  assign pg_mode = ctrl_q.operating_mode_sel == `DTW_MODE_PG_DEAD;
  assign dead_mode = cmp_mode | pg_mode;
  // compare one feeds compare mode, pulse input feeds pulse mode
  assign src = cmp_mode ? compare_sig_one : pulse_gen_input;

  assign new_mode = hwdata[`DTW_MODE_LSB +: 3];
  assign new_dead_mode = (new_mode == `DTW_MODE_CMP_DEAD) || (new_mode == `DTW_MODE_PG_DEAD);
  assign new_src = (new_mode == `DTW_MODE_CMP_DEAD) ? compare_sig_one : pulse_gen_input;
  assign preset = wr_ctrl & new_dead_mode;

  assign edge_det = dead_mode & (src != src_q);
  assign tick = div_tick(ctrl_q.clk_div, pre_q);
  assign expire = (phase_q == DTW_DELAY) & tick & (cnt_q <= DEAD_W'(1));

  // address phase: capture writes, prepare read data
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 12'h000;
    end else if (clk_en) begin
      wr_pend_q <= addr_ok & hwrite;
      wr_addr_q <= haddr;
    end
  end

  always_comb begin
    rdata_d = 32'h0000_0000;
    case (haddr)
      `DTW_CTRL_OFS: begin
        rdata_d[`DTW_MODE_LSB +: 3] = ctrl_q.operating_mode_sel;
        rdata_d[`DTW_POL_LSB +: 2] = ctrl_q.output_polarity_sel;
        rdata_d[`DTW_GATE_LSB +: 2] = ctrl_q.gate_source_sel;
        rdata_d[`DTW_DIV_LSB +: 3] = ctrl_q.clk_div;
      end
      `DTW_DEAD_OFS: rdata_d[DEAD_W-1:0] = dead_q;
      `DTW_STAT_OFS: begin
        rdata_d[0] = wave_out_zero;
        rdata_d[1] = wave_out_one;
        rdata_d[2] = pulse_gen_gate_out;
        rdata_d[3] = phase_q == DTW_DELAY;
        rdata_d[16 +: DEAD_W] = cnt_q;
      end
      default: rdata_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else if (clk_en) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (addr_ok & ~hwrite) begin
        hrdata <= rdata_d;
      end
    end
  end

  // software registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= dtw_ctrl_t'(`DTW_CTRL_RST);
      dead_q <= DEAD_W'(`DTW_DEAD_RST);
    end else if (clk_en) begin
      if (wr_ctrl) begin
        ctrl_q.operating_mode_sel <= new_mode;
        ctrl_q.output_polarity_sel <= hwdata[`DTW_POL_LSB +: 2];
        ctrl_q.gate_source_sel <= hwdata[`DTW_GATE_LSB +: 2];
        ctrl_q.clk_div <= hwdata[`DTW_DIV_LSB +: 3];
      end
      if (wr_dead) begin
        dead_q <= hwdata[DEAD_W-1:0];
      end
    end
  end

  // prescaler restarts with each timer load so the first step is a full tick
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pre_q <= 7'h00;
    end else if (clk_en) begin
      if (edge_det | preset) begin
        pre_q <= 7'h01;
      end else begin
        pre_q <= pre_q + 7'h01;
      end
    end
  end

  // source history for edge detection
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      src_q <= 1'b0;
    end else if (clk_en) begin
      src_q <= preset ? new_src : src;
    end
  end

  // dead-time timer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_q <= DTW_IDLE;
      cnt_q <= '0;
    end else if (clk_en) begin
      if (preset || !dead_mode) begin
        phase_q <= DTW_IDLE;
        cnt_q <= '0;
      end else if (edge_det) begin
        // an edge while counting reloads, so a short pulse never reaches the late output
        cnt_q <= dead_q;
        phase_q <= (dead_q == '0) ? DTW_IDLE : DTW_DELAY;
      end else if (phase_q == DTW_DELAY && tick) begin
        cnt_q <= cnt_q - DEAD_W'(1);
        if (expire) begin
          phase_q <= DTW_IDLE;
        end
      end
    end
  end

  // next normal-polarity pair; the output flops load it with polarity applied,
  // so a source edge reaches the pins one cycle after the source moves
  always_comb begin
    n0_d = n0_q;
    n1_d = n1_q;
    if (preset) begin
      n0_d = new_src;
      n1_d = ~new_src;
    end else if (!dead_mode) begin
      n0_d = 1'b0;
      n1_d = 1'b0;
    end else if (edge_det) begin
      if (src) begin
        n1_d = 1'b0;
        n0_d = (dead_q == '0);
      end else begin
        n0_d = 1'b0;
        n1_d = (dead_q == '0);
      end
    end else if (expire) begin
      n0_d = src_q;
      n1_d = ~src_q;
    end
  end

  // normal-polarity pair
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      n0_q <= 1'b0;
      n1_q <= 1'b0;
    end else if (clk_en) begin
      n0_q <= n0_d;
      n1_q <= n1_d;
    end
  end

  // polarity for the preset and for running updates
  always_comb begin
    if (preset) begin
      pair_d = apply_pol(hwdata[`DTW_POL_LSB +: 2], n0_d, n1_d);
    end else if (!dead_mode) begin
      pair_d = '0;
    end else begin
      pair_d = apply_pol(ctrl_q.output_polarity_sel, n0_d, n1_d);
    end
  end

  // output flops load together with the internal pair
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wave_out_zero <= 1'b0;
      wave_out_one <= 1'b0;
    end else if (clk_en) begin
      wave_out_zero <= pair_d.wave_out_zero;
      wave_out_one <= pair_d.wave_out_one;
    end
  end

  // gate output
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pulse_gen_gate_out <= 1'b0;
    end else if (clk_en) begin
      if (!pg_mode) begin
        pulse_gen_gate_out <= 1'b0;
      end else begin
        case (ctrl_q.gate_source_sel)
          `DTW_GATE_ZERO: pulse_gen_gate_out <= compare_sig_zero;
          `DTW_GATE_ONE: pulse_gen_gate_out <= compare_sig_one;
          `DTW_GATE_OR: pulse_gen_gate_out <= compare_sig_zero | compare_sig_one;
          default: pulse_gen_gate_out <= 1'b0;
        endcase
      end
    end
  end

endmodule : dtw_top

// file: design/dtw_cfg.svh
`ifndef DTW_CFG_SVH
`define DTW_CFG_SVH
// register byte offsets
`define DTW_CTRL_OFS 12'h000
`define DTW_DEAD_OFS 12'h004
`define DTW_STAT_OFS 12'h008
// control register fields
`define DTW_MODE_LSB 0
`define DTW_POL_LSB 4
`define DTW_GATE_LSB 8
`define DTW_DIV_LSB 12
// mode encodings
`define DTW_MODE_CMP_DEAD 3'h4
`define DTW_MODE_PG_DEAD 3'h7
// gate source encodings
`define DTW_GATE_OFF 2'h0
`define DTW_GATE_ZERO 2'h1
`define DTW_GATE_ONE 2'h2
`define DTW_GATE_OR 2'h3
// reset values
`define DTW_CTRL_RST 16'h0000
`define DTW_DEAD_RST 16'h0000
`endif

// file: design/dtw_pkg.sv
package dtw_pkg;
  typedef struct packed {
    logic [2:0] clk_div;
    logic [1:0] gate_source_sel;
    logic [1:0] output_polarity_sel;
    logic [2:0] operating_mode_sel;
  } dtw_ctrl_t;
  typedef struct packed {
    logic wave_out_zero;
    logic wave_out_one;
  } dtw_pair_t;
  typedef enum logic {DTW_IDLE, DTW_DELAY} dtw_phase_t;
endpackage : dtw_pkg

// file: tb/dtw_top_sva.sv
`timescale 1ns/1ps
module dtw_top_sva (
  // clock, bus
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  // pins
  input wire logic compare_sig_zero,
  input wire logic compare_sig_one,
  input wire logic pulse_gen_input,
  input wire logic wave_out_zero,
  input wire logic wave_out_one,
  input wire logic pulse_gen_gate_out
);
  logic ph_q;
  logic [11:0] a_q;
  logic [15:0] ctl_q, dead_q;
  wire wr = ph_q && a_q == 12'h000;
  wire cm = ctl_q[2:0] == 3'h4;
  wire pm = ctl_q[2:0] == 3'h7;
  wire p0 = ctl_q[5:4] == 2'h0;
  wire d3 = dead_q == 16'h0003 && ctl_q[14:12] == 3'h0;
  wire ws = hwdata[2:0] == 3'h4 ? compare_sig_one : pulse_gen_input;
  wire iz = hwdata[4];
  wire io = hwdata[4] ^ hwdata[5];
  // shadow registers, updated at the data-phase edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_q <= 1'b0;
      a_q <= 12'h000;
      ctl_q <= 16'h0000;
      dead_q <= 16'h0000;
    end else if (clk_en) begin
      ph_q <= hsel && hready && htrans[1] && hwrite;
      a_q <= haddr;
      if (wr) ctl_q <= hwdata[15:0];
      if (ph_q && a_q == 12'h004) dead_q <= hwdata[15:0];
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn || !clk_en);
  sequence s_rise;
    cm && p0 && d3 && $past(cm) ##0 $rose(compare_sig_one);
  endsequence
  a_mode_preset: assert property (wr && (hwdata[2:0] == 3'h4 || hwdata[2:0] == 3'h7) |=>
    wave_out_zero == $past(ws ^ iz) && wave_out_one == $past(!ws ^ io)) else $error("bad preset");
  a_gate_low: assert property (cm && $past(cm) |-> !pulse_gen_gate_out) else $error("gate not low");
  a_gate_select: assert property ($past(pm) |-> pulse_gen_gate_out ==
    ($past(ctl_q[8] && compare_sig_zero) || $past(ctl_q[9] && compare_sig_one))) else $error("bad gate");
  a_rise_cut: assert property (cm && p0 && $past(cm) ##0 $rose(compare_sig_one) |-> ##2 !wave_out_one)
    else $error("one not cut");
  a_fall_cut: assert property (cm && p0 && $past(cm) ##0 $fell(compare_sig_one) |-> ##2 !wave_out_zero)
    else $error("zero not cut");
  a_quick_cut: assert property (s_rise |=> !wave_out_one) else $error("one not cut at once");
  a_dead_three: assert property (s_rise ##1 compare_sig_one[*3] |-> !wave_out_zero ##1 wave_out_zero)
    else $error("bad dead time");
  a_short_drop: assert property (s_rise ##1 !compare_sig_one |-> !wave_out_zero[*4] ##0 !wave_out_one
    ##1 (wave_out_one && !wave_out_zero)) else $error("bad short pulse");
  a_no_overlap: assert property ((cm || pm) && p0 && $past((cm || pm) && p0) |->
    !(wave_out_zero && wave_out_one)) else $error("pair overlaps");
endmodule : dtw_top_sva
bind dtw_top dtw_top_sva chk (.hclk, .hresetn, .clk_en, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
  .compare_sig_zero, .compare_sig_one, .pulse_gen_input, .wave_out_zero, .wave_out_one, .pulse_gen_gate_out);

// file: tb/dtw_src_model.sv
`timescale 1ns/1ps
module dtw_src_model (
  // levels: compare zero, compare one, pulse
  input wire logic [2:0] lvl,
  // sources
  output logic compare_sig_zero,
  output logic compare_sig_one,
  output logic pulse_gen_input
);
  // no power stage attached, so any polarity is safe
  assign {compare_sig_zero, compare_sig_one, pulse_gen_input} = lvl;
endmodule : dtw_src_model

// file: tb/dtw_top_tb.sv
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("[FAIL] %0t %0h %0h", $time, g, e); end end
module dtw_top_tb;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [11:0] haddr = 12'h000;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [2:0] lvl = 3'h0;
  logic clk_en = 1'b1;
  logic hreadyout, hresp, c0, c1, pg, wz, wo, gt, iz, io;
  logic [31:0] hrdata, rd;
  int num_errors = 0;
  int total_checks = 0;
  always #25 hclk = ~hclk;
  dtw_src_model src (.lvl(lvl), .compare_sig_zero(c0), .compare_sig_one(c1), .pulse_gen_input(pg));
  dtw_top uut (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .compare_sig_zero(c0), .compare_sig_one(c1), .pulse_gen_input(pg), .wave_out_zero(wz),
    .wave_out_one(wo), .pulse_gen_gate_out(gt));
  task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    @(negedge hclk);
  endtask : bus
  task automatic wc(input logic [1:0] s, p, input logic [2:0] m);
    bus(12'h000, 1'b1, {22'h0, s, 2'h0, p, 1'b0, m});
  endtask : wc
  task automatic step(input logic [2:0] v, input int n);
    @(posedge hclk);
    lvl <= v;
    repeat (n) @(posedge hclk);
    @(negedge hclk);
  endtask : step
  task automatic final_report();
    if (num_errors == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : final_report
  initial begin
    repeat (4000) @(posedge hclk);
    num_errors++;
    final_report();
  end
  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    bus(12'h000, 1'b0, 32'h0);
    `CHK({rd, wz, wo, gt}, 35'h0)
    `CHK(hresp, 1'b0)
    bus(12'h004, 1'b1, 32'h0000_0003);
    bus(12'h004, 1'b0, 32'h0);
    `CHK(rd, 32'h0000_0003)
    bus(12'h00c, 1'b0, 32'h0);
    `CHK(rd, 32'h0)
    for (int p = 0; p < 4; p++) begin
      iz = p[0];
      io = p[0] ^ p[1];
      step(3'b100, 0);
      wc(2'h3, p[1:0], 3'h4);
      `CHK({wz, wo, gt}, {iz, !io, 1'b0})
      step(3'b110, 2);
      `CHK({wz, wo}, {iz, io})
      step(3'b110, 2);
      `CHK({wz, wo}, {!iz, io})
      step(3'b100, 2);
      `CHK({wz, wo}, {iz, io})
      step(3'b100, 2);
      `CHK({wz, wo}, {iz, !io})
      step(3'b110, 0);
      step(3'b100, 6);
      `CHK({wz, wo}, {iz, !io})
      bus(12'h008, 1'b0, 32'h0);
      `CHK(rd[1:0], {!io, iz})
    end
    for (int s = 0; s < 4; s++) begin
      wc(s[1:0], 2'h0, 3'h7);
      `CHK({wz, wo}, 2'b01)
      for (int v = 0; v < 4; v++) begin
        step({v[0], v[1], 1'b0}, 2);
        `CHK({gt, wz, wo}, {(s[0] && v[0]) || (s[1] && v[1]), 2'b01})
      end
    end
    step(3'b001, 5);
    `CHK({wz, wo}, 2'b10)
    step(3'b000, 5);
    `CHK({wz, wo}, 2'b01)
    step(3'b001, 0);
    step(3'b000, 6);
    `CHK({wz, wo}, 2'b01)
    step(3'b001, 0);
    wc(2'h0, 2'h1, 3'h7);
    `CHK({wz, wo}, 2'b01)
    step(3'b000, 5);
    `CHK({wz, wo}, 2'b10)
    @(posedge hclk);
    clk_en <= 1'b0;
    step(3'b001, 5);
    `CHK({wz, wo}, 2'b10)
    @(posedge hclk);
    clk_en <= 1'b1;
    step(3'b001, 5);
    `CHK({wz, wo}, 2'b01)
    bus(12'h000, 1'b1, 32'h0000_1007);
    `CHK({wz, wo}, 2'b10)
    step(3'b000, 4);
    `CHK({wz, wo}, 2'b00)
    step(3'b000, 3);
    `CHK({wz, wo}, 2'b01)
    final_report();
  end
endmodule : dtw_top_tb
